// >>> hdl/isol_map.svh
`ifndef ISOL_MAP_SVH
`define ISOL_MAP_SVH
`define ISOL_OP_HI 13
`define ISOL_OP_LO 8
`define ISOL_LIT_HI 7
`define ISOL_DEST_BIT 7
`define ISOL_ADDR_HI 6
`define ISOL_OPC_INCSKIP 6'h0f
`define ISOL_OPC_ORLIT 6'h38
`define ISOL_OPC_ORFILE 6'h04
`define ISOL_OPC_LDLIT4 4'hc
`define ISOL_LDLIT_LO 10
`define ISOL_W_RESET 8'h00
`define ISOL_Z_RESET 1'b0
`define ISOL_ONE 8'h01
`define ISOL_ZERO8 8'h00
`endif

// >>> hdl/isol_pkg.sv
package isol_pkg;
  typedef enum logic [2:0] {
    ISOL_NONE,
    ISOL_INCR_SKIP_ZERO,
    ISOL_OR_LITERAL,
    ISOL_LOAD_LITERAL,
    ISOL_OR_FILE
  } isol_op_t;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } isol_instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } isol_fwrite_t;
endpackage

// >>> hdl/isol_decode.sv
`timescale 1ns/100ps
`include "isol_map.svh"
// What this block does
// RULE1 - opcode 001111 selects increment-skip; bit7 destination, bits 6:0 file address
// RULE2 - increment file by one, to W if d=0 else file; status untouched
// RULE3 - zero increment result squashes next fetched word, running a no-operation instead
// RULE4 - opcode 111000 ORs W with literal into W and updates zero flag
// RULE5 - opcode 1100xx loads literal into W, status untouched
// RULE6 - opcode 000100 ORs W with file register and updates zero flag
// RULE7 - OR-file result goes to W if d=0, else back to file register
// RULE8 - zero flag set when 8-bit result is zero, else cleared
module isol_decode (
  input wire logic clk, // instruction clock
  input wire logic rst_b, // async reset, active low
  input wire isol_pkg::isol_instr_t instr, // fetched word with valid
  input wire logic [7:0] fileRdData, // file register at address bits 6:0
  output isol_pkg::isol_fwrite_t fileWr, // file register write, one cycle
  output logic [6:0] fileRdAddr, // file read address, straight from the word
  output logic [7:0] wReg, // working register
  output logic zFlag, // zero flag
  output logic zWe, // pulse: zero flag updated this cycle
  output logic skipNop // high while the squashed slot executes
);
  import isol_pkg::*;

  isol_op_t op;
  logic destSel;
  logic [6:0] addr;
  logic [7:0] lit;
  logic [7:0] incSum;
  logic [7:0] orFile;
  logic [7:0] orLit;
  logic live;
  logic [7:0] wReg_r;
  logic zFlag_r;
  logic zWe_r;
  logic skip_r;
  logic skip_nxt;
  isol_fwrite_t fileWr_r;

  assign addr = instr.word[`ISOL_ADDR_HI:0]; // RULE1
  assign destSel = instr.word[`ISOL_DEST_BIT]; // RULE1
  assign lit = instr.word[`ISOL_LIT_HI:0];
  // a squashed word is ignored whatever it encodes
  assign live = instr.valid && !skip_r; // RULE3

  always_comb begin
    op = ISOL_NONE;
    if (instr.word[`ISOL_OP_HI:`ISOL_OP_LO] == `ISOL_OPC_INCSKIP) begin
      op = ISOL_INCR_SKIP_ZERO; // RULE1
    end else if (instr.word[`ISOL_OP_HI:`ISOL_OP_LO] == `ISOL_OPC_ORLIT) begin
      op = ISOL_OR_LITERAL; // RULE4
    end else if (instr.word[`ISOL_OP_HI:`ISOL_LDLIT_LO] == `ISOL_OPC_LDLIT4) begin
      op = ISOL_LOAD_LITERAL; // RULE5
    end else if (instr.word[`ISOL_OP_HI:`ISOL_OP_LO] == `ISOL_OPC_ORFILE) begin
      op = ISOL_OR_FILE; // RULE6
    end
  end

  assign incSum = fileRdData + `ISOL_ONE; // RULE2
  assign orFile = wReg_r | fileRdData; // RULE6
  assign orLit = wReg_r | lit; // RULE4
  // not registered: the file read has to settle inside the executing cycle
  assign fileRdAddr = addr;

  // working register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wReg_r <= `ISOL_W_RESET;
    end else if (live) begin
      case (op)
        ISOL_INCR_SKIP_ZERO: if (!destSel) wReg_r <= incSum; // RULE2
        ISOL_OR_LITERAL: wReg_r <= orLit; // RULE4
        ISOL_LOAD_LITERAL: wReg_r <= lit; // RULE5
        ISOL_OR_FILE: if (!destSel) wReg_r <= orFile; // RULE7
        default: wReg_r <= wReg_r;
      endcase
    end
  end

  // zero flag; increment-skip and literal load leave it alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zFlag_r <= `ISOL_Z_RESET;
      zWe_r <= 1'b0;
    end else begin
      zWe_r <= 1'b0;
      if (live && op == ISOL_OR_LITERAL) begin
        zFlag_r <= (orLit == `ISOL_ZERO8); // RULE8
        zWe_r <= 1'b1;
      end else if (live && op == ISOL_OR_FILE) begin
        zFlag_r <= (orFile == `ISOL_ZERO8); // RULE8
        zWe_r <= 1'b1;
      end
    end
  end

  // file write-back
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fileWr_r <= '0;
    end else begin
      fileWr_r.we <= 1'b0;
      fileWr_r.addr <= addr;
      fileWr_r.data <= `ISOL_ZERO8;
      if (live && destSel && op == ISOL_INCR_SKIP_ZERO) begin
        fileWr_r.we <= 1'b1; // RULE2
        fileWr_r.data <= incSum;
      end else if (live && destSel && op == ISOL_OR_FILE) begin
        fileWr_r.we <= 1'b1; // RULE7
        fileWr_r.data <= orFile;
      end
    end
  end

  // skip: the following valid slot becomes a no-operation
  always_comb begin
    skip_nxt = skip_r;
    if (instr.valid) begin
      skip_nxt = live && op == ISOL_INCR_SKIP_ZERO && incSum == `ISOL_ZERO8; // RULE3
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= skip_nxt;
    end
  end

  assign wReg = wReg_r;
  assign zFlag = zFlag_r;
  assign zWe = zWe_r;
  assign skipNop = skip_r;
  assign fileWr = fileWr_r;

  property p_zero_flag;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_OR_LITERAL) |=> (zFlag == (wReg == `ISOL_ZERO8)) && zWe;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE8

  property p_load;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_LOAD_LITERAL) |=> (wReg == $past(lit)) && !zWe && $stable(zFlag);
  endproperty
  a_load: assert property (p_load) else $error("literal load wrong"); // RULE5

  property p_orlit;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_OR_LITERAL) |=> wReg == ($past(wReg) | $past(lit));
  endproperty
  a_orlit: assert property (p_orlit) else $error("or literal wrong"); // RULE4

  property p_inc_w;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_INCR_SKIP_ZERO && !destSel) |=>
        wReg == $past(incSum) && !fileWr.we && $stable(zFlag);
  endproperty
  a_inc_w: assert property (p_inc_w) else $error("increment to W wrong"); // RULE2

  property p_inc_f;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_INCR_SKIP_ZERO && destSel) |=>
        fileWr.we && fileWr.data == $past(incSum) && $stable(wReg);
  endproperty
  a_inc_f: assert property (p_inc_f) else $error("increment to file wrong"); // RULE2

  property p_skip;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_INCR_SKIP_ZERO && incSum == `ISOL_ZERO8) |=> skipNop;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not taken"); // RULE3

  property p_squash;
    @(posedge clk) disable iff (!rst_b)
      (skipNop && instr.valid) |=> $stable(wReg) && !fileWr.we && !zWe && !skipNop;
  endproperty
  a_squash: assert property (p_squash) else $error("squashed slot acted"); // RULE3

  property p_orfile;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_OR_FILE && destSel) |=>
        fileWr.we && fileWr.data == $past(orFile) && $stable(wReg) && zWe;
  endproperty
  a_orfile: assert property (p_orfile) else $error("or file wrong"); // RULE7

  property p_orfile_w;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_OR_FILE && !destSel) |=> wReg == $past(orFile) && !fileWr.we;
  endproperty
  a_orfile_w: assert property (p_orfile_w) else $error("or file to W wrong"); // RULE6

  property p_inc_addr;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_INCR_SKIP_ZERO && destSel) |=>
        fileWr.addr == $past(instr.word[`ISOL_ADDR_HI:0]);
  endproperty
  a_inc_addr: assert property (p_inc_addr) else $error("increment address wrong"); // RULE1

  property p_no_skip;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_INCR_SKIP_ZERO && incSum != `ISOL_ZERO8) |=>
        !skipNop && $stable(zFlag);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip without zero result"); // RULE3

  property p_orfile_z;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_OR_FILE) |=>
        zWe && (zFlag == ($past(orFile) == `ISOL_ZERO8));
  endproperty
  a_orfile_z: assert property (p_orfile_z) else $error("or file zero flag wrong"); // RULE8

  // unknown opcodes fall through as a no-operation
  property p_unknown;
    @(posedge clk) disable iff (!rst_b)
      (live && op == ISOL_NONE) |=> $stable(wReg) && $stable(zFlag) && !fileWr.we && !zWe;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode acted"); // RULE1

  c_skip: cover property (@(posedge clk) disable iff (!rst_b) skipNop && instr.valid);
  c_orfile: cover property (@(posedge clk) disable iff (!rst_b) live && op == ISOL_OR_FILE);
  c_zero: cover property (@(posedge clk) disable iff (!rst_b) zWe && zFlag);
  c_load: cover property (@(posedge clk) disable iff (!rst_b) live && op == ISOL_LOAD_LITERAL);
endmodule

// >>> verification/tb_incskip_or_literal_ops.sv
`timescale 1ns/100ps
module tb_incskip_or_literal_ops;
  import isol_pkg::*;
  logic clk = 1'b0;
  logic rstB = 1'b0;
  isol_instr_t instr = '0;
  logic [7:0] fileRd = 8'h00;
  isol_fwrite_t fileWr;
  logic [6:0] rdAddr;
  logic [7:0] wReg;
  logic zFlag;
  logic zWe;
  logic skipNop;
  logic [7:0] mW = 8'h00;
  logic mZ = 1'b0;
  logic mSkip = 1'b0;
  logic [26:0] notes[$];
  logic [5:0] ops[6] = '{6'h0f, 6'h38, 6'h30, 6'h33, 6'h04, 6'h0a};
  int errors = 0;
  int total_checks = 0;
  isol_decode i_isol_decode (.clk(clk), .rst_b(rstB), .instr(instr), .fileRdData(fileRd),
    .fileWr(fileWr), .fileRdAddr(rdAddr), .wReg(wReg), .zFlag(zFlag), .zWe(zWe),
    .skipNop(skipNop));
  always #5 clk = ~clk;
  task automatic check(string what, logic [26:0] exp, logic [26:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reference model runs alongside the drive, result noted for the monitor
  task automatic exec(logic [13:0] w, logic [7:0] f);
    logic [7:0] r;
    logic we;
    logic zw;
    we = 1'b0;
    zw = 1'b0;
    r = mW;
    @(posedge clk);
    #1;
    instr = '{valid: 1'b1, word: w};
    fileRd = f;
    #1;
    check("read address", {20'h0, w[6:0]}, {20'h0, rdAddr});
    if (mSkip) mSkip = 1'b0;
    else begin
      case (w[13:8]) inside
        6'h0f: begin r = f + 8'h01; we = w[7]; mSkip = (r == 8'h00); end
        6'h38: begin r = mW | w[7:0]; zw = 1'b1; end
        6'b1100??: r = w[7:0];
        6'h04: begin r = mW | f; we = w[7]; zw = 1'b1; end
        default: r = mW;
      endcase
      if (!we) mW = r;
      if (zw) mZ = (r == 8'h00);
    end
    notes.push_back({mW, mZ, zw, we, we ? w[6:0] : 7'h00, we ? r : 8'h00, mSkip});
  endtask
  task automatic idle();
    @(posedge clk);
    #1;
    instr.valid = 1'b0;
  endtask
  // valid seen at an edge means a result lands just after it
  always @(posedge clk) begin
    if (rstB && instr.valid) begin
      #5;
      check("outputs", notes.pop_front(), {wReg, zFlag, zWe, fileWr.we,
        fileWr.we ? fileWr.addr : 7'h00, fileWr.data, skipNop});
    end
  end
  initial begin
    #50000;
    errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9f53));
    repeat (5) @(posedge clk);
    #1 rstB = 1'b1;
    check("reset", 27'h0, {wReg, zFlag, zWe, fileWr, skipNop});
    exec(14'h0f85, 8'hff);
    exec(14'h3835, 8'h00);
    exec(14'h309a, 8'h00);
    exec(14'h3835, 8'h00);
    exec(14'h3191, 8'h00);
    exec(14'h0493, 8'h13);
    exec(14'h0413, 8'h13);
    exec(14'h3200, 8'h00);
    exec(14'h0400, 8'h00);
    exec(14'h3800, 8'h00);
    exec(14'h33a5, 8'h00);
    exec(14'h0400, 8'h00);
    exec(14'h0f22, 8'h41);
    exec(14'h0f33, 8'hff);
    idle();
    idle();
    exec(14'h3355, 8'h00);
    exec(14'h2abc, 8'h12);
    repeat (300) exec({ops[$urandom_range(5)], 8'($urandom)}, 8'($urandom));
    exec(14'h0f00, 8'hff);
    idle();
    @(posedge clk);
    #1 rstB = 1'b0;
    #1 check("mid reset", 27'h0, {wReg, zFlag, zWe, fileWr, skipNop});
    mW = 8'h00;
    mZ = 1'b0;
    mSkip = 1'b0;
    @(posedge clk);
    #1 rstB = 1'b1;
    exec(14'h3835, 8'h00);
    idle();
    repeat (3) @(posedge clk);
    check("notes left", 27'h0, 27'(notes.size()));
    finish_test();
  end
endmodule
